//--- t2c_timer2.sv
// Function
// - sixteen-bit up counter kept as low and high bytes, each separately accessible
// - counter select 0 counts peripheral clocks, 1 counts count pin falling edges
// - run bit gates counting; clearing it freezes the count
// - rollover sets overflow flag requesting interrupt; only software clears it
// - no overflow flag in baud-rate or clock-out mode
// - trigger pin falling edge with trigger enable sets external flag
// - trigger enable 0 ignores trigger pin completely
// - trigger edge also captures or reloads in capture or reload mode
// - rx baud select picks timer1 overflows (0) or our overflows (1)
// - tx baud select picks timer1 overflows (0) or our overflows (1)
// - capture select 0 means auto-reload, 1 means capture on trigger edge
// - either baud select bit forces auto-reload, ignoring capture select
// - clock-out enable with counter select 0 drives a clock on count pin
// - low reload/capture byte latches capture, otherwise holds reload low byte
// - reload copies both reload/capture bytes into the count bytes
// - counter keeps counting during a capture
// - baud-rate mode rollover emits a shift-clock pulse instead of the flag
// - clock-out output is a 50% duty square wave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module t2c_timer2
  import t2c_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [T2C_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [T2C_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  count_pin_i,
  output logic                       count_pin_o,
  output logic                       count_pin_oe,
  input  wire logic                  trigger_pin_i,
  input  wire logic                  timer1_overflow_i,
  output logic                       rx_baud_tick,
  output logic                       tx_baud_tick,
  output logic                       timer_irq_req
);

  // ==========================================================================
  // register bus
  t2c_regbus_if rb ();

  t2c_axil_slave u_slave
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .rb      (rb.bus_end)
  );

  // ==========================================================================
  // pin synchronisers
  logic count_fall;
  logic trig_fall;

  t2c_pin_sync u_count_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_i   (count_pin_i),
    .level_o (),
    .fall_o  (count_fall)
  );

  t2c_pin_sync u_trig_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin_i   (trigger_pin_i),
    .level_o (),
    .fall_o  (trig_fall)
  );

  // ==========================================================================
  // address decode
  logic                 wr_in_range;
  logic                 rd_in_range;
  logic [T2C_IDX_W-1:0] wr_idx;
  logic [T2C_IDX_W-1:0] rd_idx;

  assign wr_in_range = (rb.wr_addr[T2C_ADDR_W-1:T2C_IDX_W+2] == '0);
  assign rd_in_range = (rb.rd_addr[T2C_ADDR_W-1:T2C_IDX_W+2] == '0);
  assign wr_idx      = rb.wr_addr[T2C_IDX_W+1:2];
  assign rd_idx      = rb.rd_addr[T2C_IDX_W+1:2];

  function automatic logic idx_known(input logic [T2C_IDX_W-1:0] idx);
    idx_known = (idx >= T2C_IDX_CONTROL) && (idx <= T2C_IDX_CNT_HI);
  endfunction

  assign rb.wr_ok = wr_in_range & idx_known(wr_idx);
  assign rb.rd_ok = rd_in_range & idx_known(rd_idx);

  // ==========================================================================
  // timer state
  logic [7:0]  ctl_reg, ctl_next;
  logic        clkout_en_reg, clkout_en_next;
  logic [15:0] rcap_reg, rcap_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        pin_o_reg, pin_o_next;
  logic        pin_oe_reg, pin_oe_next;
  logic        rx_tick_reg, rx_tick_next;
  logic        tx_tick_reg, tx_tick_next;
  logic        irq_reg, irq_next;

  t2c_mode_t mode;
  logic      baud_sel;
  logic      drive_clk;
  logic      tick;
  logic      rollover;
  logic      trig;
  logic      wr_ctl, wr_mod, wr_rcl, wr_rch, wr_cnl, wr_cnh;

  always_comb
  begin
    baud_sel  = ctl_reg[T2C_CTL_RX_BAUD_SELECT] | ctl_reg[T2C_CTL_TX_BAUD_SELECT];
    drive_clk = clkout_en_reg & ~ctl_reg[T2C_CTL_COUNTER_SELECT];
    if (baud_sel)
      mode = T2C_M_BAUD;
    else if (drive_clk)
      mode = T2C_M_CLKOUT;
    else if (ctl_reg[T2C_CTL_CAPTURE_SELECT])
      mode = T2C_M_CAPTURE;
    else
      mode = T2C_M_RELOAD;
    // count source and gating
    tick = ctl_reg[T2C_CTL_RUN_BIT] & (ctl_reg[T2C_CTL_COUNTER_SELECT] ? count_fall : 1'b1);
    rollover = tick & (cnt_reg == T2C_COUNT_MAX);
    trig     = trig_fall & ctl_reg[T2C_CTL_TRIGGER_ENABLE];
  end

  // ==========================================================================
  // write strobes, one per mapped byte
  logic wr_hit;

  always_comb
  begin
    wr_hit = rb.wr_en & rb.wr_be & rb.wr_ok;
    wr_ctl = wr_hit & (wr_idx == T2C_IDX_CONTROL);
    wr_mod = wr_hit & (wr_idx == T2C_IDX_MODE);
    wr_rcl = wr_hit & (wr_idx == T2C_IDX_RCAP_LO);
    wr_rch = wr_hit & (wr_idx == T2C_IDX_RCAP_HI);
    wr_cnl = wr_hit & (wr_idx == T2C_IDX_CNT_LO);
    wr_cnh = wr_hit & (wr_idx == T2C_IDX_CNT_HI);
  end

  // ==========================================================================
  // next-state logic
  always_comb
  begin
    cnt_next       = cnt_reg;
    rcap_next      = rcap_reg;
    ctl_next       = ctl_reg;
    clkout_en_next = clkout_en_reg;
    // counting, reload on rollover except in capture mode
    if (tick)
    begin
      if (rollover && mode != T2C_M_CAPTURE)
        cnt_next = rcap_reg;
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    // trigger-driven reload
    if (trig && mode == T2C_M_RELOAD)
      cnt_next = rcap_reg;
    // software byte writes to the count
    if (wr_cnl)
      cnt_next[7:0] = rb.wr_data;
    if (wr_cnh)
      cnt_next[15:8] = rb.wr_data;
    // reload/capture bytes
    if (wr_rcl)
      rcap_next[7:0] = rb.wr_data;
    if (wr_rch)
      rcap_next[15:8] = rb.wr_data;
    if (trig && mode == T2C_M_CAPTURE)
      rcap_next = cnt_reg;
    // control and mode registers
    if (wr_ctl)
      ctl_next = rb.wr_data;
    if (wr_mod)
      clkout_en_next = rb.wr_data[T2C_MOD_CLOCK_OUT_ENABLE];
    // hardware sets win over a same-cycle software clear
    if (rollover && (mode == T2C_M_CAPTURE || mode == T2C_M_RELOAD))
      ctl_next[T2C_CTL_OVERFLOW_FLAG] = 1'b1;
    if (trig)
      ctl_next[T2C_CTL_EXTERNAL_FLAG] = 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_reg       <= T2C_RST_CONTROL;
      clkout_en_reg <= T2C_RST_MODE[T2C_MOD_CLOCK_OUT_ENABLE];
      rcap_reg      <= T2C_RST_RCAP;
      cnt_reg       <= T2C_RST_COUNT;
    end
    else
    begin
      ctl_reg       <= ctl_next;
      clkout_en_reg <= clkout_en_next;
      rcap_reg      <= rcap_next;
      cnt_reg       <= cnt_next;
    end
  end

  // ==========================================================================
  // pin, baud tick and request outputs
  always_comb
  begin
    pin_o_next = pin_o_reg;
    // square wave: one half period per rollover
    if (!drive_clk)
      pin_o_next = 1'b0;
    else if (rollover)
      pin_o_next = ~pin_o_reg;
    pin_oe_next  = drive_clk;
    rx_tick_next = ctl_reg[T2C_CTL_RX_BAUD_SELECT] ? rollover : timer1_overflow_i;
    tx_tick_next = ctl_reg[T2C_CTL_TX_BAUD_SELECT] ? rollover : timer1_overflow_i;
    irq_next     = ctl_next[T2C_CTL_OVERFLOW_FLAG] | ctl_next[T2C_CTL_EXTERNAL_FLAG];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o_reg   <= 1'b0;
      pin_oe_reg  <= 1'b0;
      rx_tick_reg <= 1'b0;
      tx_tick_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      pin_o_reg   <= pin_o_next;
      pin_oe_reg  <= pin_oe_next;
      rx_tick_reg <= rx_tick_next;
      tx_tick_reg <= tx_tick_next;
      irq_reg     <= irq_next;
    end
  end

  // ==========================================================================
  // read mux
  always_comb
  begin
    rb.rd_data = 8'h00;
    if (rd_in_range)
    begin
      case (rd_idx)
        T2C_IDX_CONTROL: rb.rd_data = ctl_reg;
        T2C_IDX_MODE:    rb.rd_data = {6'h00, clkout_en_reg, 1'b0};
        T2C_IDX_RCAP_LO: rb.rd_data = rcap_reg[7:0];
        T2C_IDX_RCAP_HI: rb.rd_data = rcap_reg[15:8];
        T2C_IDX_CNT_LO:  rb.rd_data = cnt_reg[7:0];
        T2C_IDX_CNT_HI:  rb.rd_data = cnt_reg[15:8];
        default:         rb.rd_data = 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // outputs
  assign count_pin_o   = pin_o_reg;
  assign count_pin_oe  = pin_oe_reg;
  assign rx_baud_tick  = rx_tick_reg;
  assign tx_baud_tick  = tx_tick_reg;
  assign timer_irq_req = irq_reg;

endmodule // t2c_timer2

//--- t2c_pkg.sv
package t2c_pkg;

  // ==========================================================================
  // bus geometry
  localparam int unsigned T2C_ADDR_W = 12;
  localparam int unsigned T2C_IDX_W  = 8;
  localparam logic [1:0]  T2C_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  T2C_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] T2C_IDX_CONTROL = 8'hC8;
  localparam logic [7:0] T2C_IDX_MODE    = 8'hC9;
  localparam logic [7:0] T2C_IDX_RCAP_LO = 8'hCA;
  localparam logic [7:0] T2C_IDX_RCAP_HI = 8'hCB;
  localparam logic [7:0] T2C_IDX_CNT_LO  = 8'hCC;
  localparam logic [7:0] T2C_IDX_CNT_HI  = 8'hCD;

  // ==========================================================================
  // counter2_control fields
  localparam int unsigned T2C_CTL_OVERFLOW_FLAG   = 7;
  localparam int unsigned T2C_CTL_EXTERNAL_FLAG   = 6;
  localparam int unsigned T2C_CTL_RX_BAUD_SELECT  = 5;
  localparam int unsigned T2C_CTL_TX_BAUD_SELECT  = 4;
  localparam int unsigned T2C_CTL_TRIGGER_ENABLE  = 3;
  localparam int unsigned T2C_CTL_RUN_BIT         = 2;
  localparam int unsigned T2C_CTL_COUNTER_SELECT  = 1;
  localparam int unsigned T2C_CTL_CAPTURE_SELECT  = 0;

  // ==========================================================================
  // counter2_mode fields
  localparam int unsigned T2C_MOD_CLOCK_OUT_ENABLE = 1;

  // ==========================================================================
  // reset values
  localparam logic [7:0]  T2C_RST_CONTROL = 8'h00;
  localparam logic [7:0]  T2C_RST_MODE    = 8'h00;
  localparam logic [15:0] T2C_RST_RCAP    = 16'h0000;
  localparam logic [15:0] T2C_RST_COUNT   = 16'h0000;
  localparam logic [15:0] T2C_COUNT_MAX   = 16'hFFFF;

  // ==========================================================================
  // operating modes
  typedef enum logic [1:0] {
    T2C_M_CAPTURE,
    T2C_M_RELOAD,
    T2C_M_BAUD,
    T2C_M_CLKOUT
  } t2c_mode_t;

endpackage

//--- t2c_regbus_if.sv
`timescale 1ns/1ps
interface t2c_regbus_if;
  import t2c_pkg::*;

  logic                  wr_en;
  logic [T2C_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  wr_be;
  logic                  wr_ok;
  logic                  rd_en;
  logic [T2C_ADDR_W-1:0] rd_addr;
  logic [7:0]            rd_data;
  logic                  rd_ok;

  modport bus_end (output wr_en, wr_addr, wr_data, wr_be, rd_en, rd_addr,
                   input wr_ok, rd_data, rd_ok);
  modport reg_end (input wr_en, wr_addr, wr_data, wr_be, rd_en, rd_addr,
                   output wr_ok, rd_data, rd_ok);
endinterface

//--- t2c_pin_sync.sv
`timescale 1ns/1ps
module t2c_pin_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o
);

  // ==========================================================================
  // two-stage synchroniser plus history stage for edge detection
  logic s1_reg, s2_reg, s3_reg;
  logic s1_next, s2_next, s3_next;

  always_comb
  begin
    s1_next = pin_i;
    s2_next = s1_reg;
    s3_next = s2_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
    end
    else
    begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign level_o = s2_reg;
  assign fall_o  = s3_reg & ~s2_reg;

endmodule // t2c_pin_sync

//--- t2c_axil_slave.sv
`timescale 1ns/1ps
module t2c_axil_slave
  import t2c_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [T2C_ADDR_W-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [T2C_ADDR_W-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  t2c_regbus_if.bus_end              rb
);

  // ==========================================================================
  // write and read channel state
  logic                  aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic [T2C_ADDR_W-1:0] awaddr_reg, awaddr_next, araddr_reg, araddr_next;
  logic [7:0]            wdata_reg, wdata_next;
  logic                  wbe_reg, wbe_next;
  logic                  awready_reg, awready_next, wready_reg, wready_next;
  logic                  bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic [1:0]            bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic                  ar_busy_reg, ar_busy_next, rvalid_reg, rvalid_next;
  logic [31:0]           rdata_reg, rdata_next;
  logic                  fire;

  always_comb
  begin
    fire         = aw_full_reg & w_full_reg & ~bvalid_reg;
    aw_full_next = aw_full_reg;
    w_full_next  = w_full_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wbe_next     = wbe_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (awvalid & awready_reg)
    begin
      aw_full_next = 1'b1;
      awaddr_next  = awaddr;
    end
    if (wvalid & wready_reg)
    begin
      w_full_next = 1'b1;
      wdata_next  = wdata[7:0];
      wbe_next    = wstrb[0];
    end
    if (fire)
    begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = rb.wr_ok ? T2C_RESP_OKAY : T2C_RESP_SLVERR;
    end
    else if (bvalid_reg & bready)
    begin
      bvalid_next = 1'b0;
    end
    awready_next = ~aw_full_next;
    wready_next  = ~w_full_next;
    ar_busy_next = arvalid & arready_reg;
    araddr_next  = (arvalid & arready_reg) ? araddr : araddr_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (ar_busy_reg)
    begin
      rvalid_next = 1'b1;
      rdata_next  = {24'h000000, rb.rd_data};
      rresp_next  = rb.rd_ok ? T2C_RESP_OKAY : T2C_RESP_SLVERR;
    end
    else if (rvalid_reg & rready)
    begin
      rvalid_next = 1'b0;
    end
    arready_next = ~ar_busy_next & ~rvalid_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awaddr_reg  <= '0;
      araddr_reg  <= '0;
      wdata_reg   <= 8'h00;
      wbe_reg     <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= T2C_RESP_OKAY;
      ar_busy_reg <= 1'b0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= T2C_RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      w_full_reg  <= w_full_next;
      awaddr_reg  <= awaddr_next;
      araddr_reg  <= araddr_next;
      wdata_reg   <= wdata_next;
      wbe_reg     <= wbe_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      ar_busy_reg <= ar_busy_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign rb.wr_en   = fire;
  assign rb.wr_addr = awaddr_reg;
  assign rb.wr_data = wdata_reg;
  assign rb.wr_be   = wbe_reg;
  assign rb.rd_en   = ar_busy_reg;
  assign rb.rd_addr = araddr_reg;
  assign awready    = awready_reg;
  assign wready     = wready_reg;
  assign bvalid     = bvalid_reg;
  assign bresp      = bresp_reg;
  assign arready    = arready_reg;
  assign rvalid     = rvalid_reg;
  assign rdata      = rdata_reg;
  assign rresp      = rresp_reg;

endmodule // t2c_axil_slave

//--- t2c_checker.sv
`timescale 1ns/1ps
module t2c_checker
  import t2c_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        count_pin_o,
  input wire logic        count_pin_oe,
  input wire logic        timer_irq_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================
  // bus steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd_take |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_wr_busy: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready ##1 s_axi_awready)
    else $error("write channels not paused");
  a_rd_busy: assert property (s_rd_take |=> !s_axi_arready [*2])
    else $error("read channel not paused");
  a_byte_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above low byte");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == T2C_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_pin_quiet: assert property (!count_pin_oe |-> !count_pin_o)
    else $error("count pin output while not driving");
  a_flag_sw_only: assert property ($fell(timer_irq_req) |-> $rose(s_axi_bvalid))
    else $error("request dropped without a write");
endmodule // t2c_checker
bind t2c_timer2 t2c_checker i_t2c_checker (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp,
  .count_pin_o, .count_pin_oe, .timer_irq_req);

//--- t2c_pin_model.sv
`timescale 1ns/1ps
module t2c_pin_model
(
  input wire logic aclk,
  input wire logic count_pin_o,
  input wire logic count_pin_oe,
  output logic     count_pin_i,
  output logic     trigger_pin_i
);
  logic cnt_lvl = 1'b1;
  // ==========================================
  // pins idle high through pull-ups
  assign count_pin_i = count_pin_oe ? count_pin_o : cnt_lvl;
  initial trigger_pin_i = 1'b1;
  task automatic count_falls(input int n);
    repeat (n)
    begin
      repeat (4) @(posedge aclk);
      cnt_lvl <= 1'b0;
      repeat (4) @(posedge aclk);
      cnt_lvl <= 1'b1;
    end
  endtask
  task automatic trig_fall();
    @(posedge aclk);
    trigger_pin_i <= 1'b0;
    repeat (4) @(posedge aclk);
    trigger_pin_i <= 1'b1;
    repeat (4) @(posedge aclk);
  endtask
endmodule // t2c_pin_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module testbench
  import t2c_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, t1_ovf;
  logic awready, wready, bvalid, arready, rvalid, pin_o, pin_oe, pin_i, trg, rx_tick, tx_tick, irq;
  logic [T2C_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, r, b;
  logic [7:0] d, e;
  int error_cnt = 0, n_tests = 0, cyc = 0, n;
  t2c_timer2 i_t2c_timer2 (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .count_pin_i(pin_i), .count_pin_o(pin_o), .count_pin_oe(pin_oe),
    .trigger_pin_i(trg), .timer1_overflow_i(t1_ovf), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .timer_irq_req(irq));
  t2c_pin_model i_t2c_pin_model (.aclk(aclk), .count_pin_o(pin_o), .count_pin_oe(pin_oe),
    .count_pin_i(pin_i), .trigger_pin_i(trg));
  // ==========================================
  // clock and watchdog
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      results();
    end
  end
  // ==========================================
  // bus tasks
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    logic a, w;
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    while (!(a && w))
    begin
      @(posedge aclk);
      if (awready) a = 1'b1;
      if (wready) w = 1'b1;
      awvalid <= !a;
      wvalid <= !w;
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    b = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [7:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata[7:0];
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, t1_ovf} = '0;
    {awaddr, araddr, wdata} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, T2C_RST_CONTROL)
    rd(T2C_IDX_MODE, d, r); `CHK(d, T2C_RST_MODE)
    rd(T2C_IDX_RCAP_LO, d, r); `CHK(d, 8'h00)
    rd(8'h10, d, r); `CHK(r, T2C_RESP_SLVERR)
    wr(8'h10, 8'h55); `CHK(b, T2C_RESP_SLVERR)
    wr(T2C_IDX_MODE, 8'hFF); `CHK(b, T2C_RESP_OKAY)
    rd(T2C_IDX_MODE, d, r); `CHK(d, 8'h02)
    wr(T2C_IDX_MODE, 8'h00);
    done("registers");
    wr(T2C_IDX_CNT_LO, 8'hFE);
    wr(T2C_IDX_CNT_HI, 8'hFF);
    wr(T2C_IDX_CONTROL, 8'h04);
    repeat (8) @(posedge aclk);
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h84)
    `CHK(irq, 1'b1)
    wr(T2C_IDX_CONTROL, 8'h80);
    rd(T2C_IDX_CNT_LO, d, r);
    repeat (6) @(posedge aclk);
    rd(T2C_IDX_CNT_LO, e, r); `CHK(e, d)
    wr(T2C_IDX_CONTROL, 8'h00); `CHK(irq, 1'b0)
    wr(T2C_IDX_CONTROL, 8'h40); `CHK(irq, 1'b1)
    done("overflow");
    wr(T2C_IDX_CNT_LO, 8'h00);
    wr(T2C_IDX_CNT_HI, 8'h00);
    wr(T2C_IDX_CONTROL, 8'h0F);
    i_t2c_pin_model.count_falls(5);
    i_t2c_pin_model.trig_fall();
    rd(T2C_IDX_RCAP_LO, d, r); `CHK(d, 8'h05)
    rd(T2C_IDX_CNT_LO, d, r); `CHK(d, 8'h05)
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h4F)
    wr(T2C_IDX_CONTROL, 8'h07);
    i_t2c_pin_model.trig_fall();
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h07)
    done("capture");
    wr(T2C_IDX_RCAP_LO, 8'h34);
    wr(T2C_IDX_RCAP_HI, 8'h12);
    wr(T2C_IDX_CONTROL, 8'h0E);
    i_t2c_pin_model.trig_fall();
    rd(T2C_IDX_CNT_LO, d, r); `CHK(d, 8'h34)
    rd(T2C_IDX_CNT_HI, d, r); `CHK(d, 8'h12)
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h4E)
    done("reload");
    wr(T2C_IDX_CONTROL, 8'h00);
    @(posedge aclk) t1_ovf <= 1'b1;
    @(posedge aclk) t1_ovf <= 1'b0;
    @(posedge aclk); `CHK(rx_tick, 1'b1)
    `CHK(tx_tick, 1'b1)
    wr(T2C_IDX_RCAP_LO, 8'hF0);
    wr(T2C_IDX_RCAP_HI, 8'hFF);
    wr(T2C_IDX_CNT_LO, 8'hF0);
    wr(T2C_IDX_CNT_HI, 8'hFF);
    wr(T2C_IDX_CONTROL, 8'h35);
    do @(posedge aclk); while (rx_tick !== 1'b1);
    n = 0;
    do begin @(posedge aclk); n++; end while (rx_tick !== 1'b1);
    `CHK(n, 16)
    `CHK(tx_tick, 1'b1)
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h35)
    done("baud");
    wr(T2C_IDX_CONTROL, 8'h00);
    wr(T2C_IDX_MODE, 8'h02);
    wr(T2C_IDX_CNT_LO, 8'hF0);
    wr(T2C_IDX_CNT_HI, 8'hFF);
    wr(T2C_IDX_CONTROL, 8'h04);
    @(posedge aclk); `CHK(pin_oe, 1'b1)
    do @(posedge aclk); while (pin_o !== 1'b1);
    n = 0;
    do begin @(posedge aclk); n++; end while (pin_o !== 1'b0);
    `CHK(n, 16)
    n = 0;
    do begin @(posedge aclk); n++; end while (pin_o !== 1'b1);
    `CHK(n, 16)
    rd(T2C_IDX_CONTROL, d, r); `CHK(d, 8'h04)
    wr(T2C_IDX_MODE, 8'h00);
    @(posedge aclk);
    `CHK(pin_oe, 1'b0)
    done("clock_out");
    results();
  end
endmodule // testbench
